// *** logic/pam_global_ctrl.sv ***
// Summary of operation
// - blank bit forces outputs to black
// - power save bit shuts analog sections down
// - two-bit pll range drives the pll
// - vertical blank enable gates vertical blanking
// - override bit shows on-screen display only
// - clamp polarity selects active clamp edge sense
// - soft reset reloads defaults except own register
// - soft reset leaves serial transfers undisturbed
// - soft reset bit clears itself when done
// - autoinc disable freezes register address
`timescale 1ns/100ps
module pam_global_ctrl
  import pam_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = PAM_DEV_ADDR
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic vblank_in,
  input wire logic clamp_in,
  output logic video_blank,
  output logic analog_shutdown,
  output logic [1:0] pll_range,
  output logic osd_only,
  output logic clamp_active
);
  logic sel_pulse, sel_read, rx_valid, tx_done;
  logic [7:0] rx_data;
  logic [7:0] gvc_q, gvc_d;
  logic [7:0] pll_q, pll_d;
  logic aid_q, aid_d;
  logic soft_reset_q, soft_reset_d;
  logic [1:0] soft_reset_cnt_q, soft_reset_cnt_d;
  logic [15:0] ptr_q, ptr_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] tx_q, tx_d;
  logic sda_out_q;
  logic blank_q, blank_d;
  logic shut_q, shut_d;
  logic [1:0] pll_rng_q, pll_rng_d;
  logic osd_q, osd_d;
  logic clamp_q, clamp_d;

  function automatic logic [7:0] read_reg(input logic [15:0] addr, input logic [7:0] gvc,
                                          input logic [7:0] pll, input logic autoinc_disable,
                                          input logic soft_reset);
    logic [7:0] val;
    val = PAM_UNMAPPED_READ;
    case (addr)
      PAM_GVC_ADDR: val = gvc & PAM_GVC_MASK;
      PAM_PLL_ADDR: val = pll & PAM_PLL_MASK;
      PAM_SRT_ADDR: begin
        val = 8'h00;
        val[PAM_AID_BIT] = autoinc_disable;
        val[PAM_SOFT_RESET_BIT] = soft_reset;
      end
      default: val = PAM_UNMAPPED_READ;
    endcase
    return val;
  endfunction : read_reg

  // the bus engine sees only the power-on reset, so a soft reset never cuts a transfer
  pam_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_bus (
    .clock(clock),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .select_pulse(sel_pulse),
    .select_read(sel_read),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_data(tx_q),
    .tx_done(tx_done)
  );

  // register file and soft reset
  always_comb begin
    gvc_d = gvc_q;
    pll_d = pll_q;
    aid_d = aid_q;
    soft_reset_d = soft_reset_q;
    soft_reset_cnt_d = soft_reset_cnt_q;
    if (soft_reset_q) begin
      gvc_d = PAM_GVC_RESET;
      pll_d = PAM_PLL_RESET;
      if (soft_reset_cnt_q == 2'h0) begin
        soft_reset_d = 1'b0;
      end else begin
        soft_reset_cnt_d = soft_reset_cnt_q - 2'h1;
      end
    end
    if (rx_valid && idx_q == 2'h2) begin
      case (ptr_q)
        // reserved bits are dropped by the mask, whatever the master writes
        PAM_GVC_ADDR: if (!soft_reset_q) gvc_d = rx_data & PAM_GVC_MASK;
        PAM_PLL_ADDR: if (!soft_reset_q) pll_d = rx_data & PAM_PLL_MASK;
        PAM_SRT_ADDR: begin
          aid_d = rx_data[PAM_AID_BIT];
          // a new request wins over the self-clear in the same cycle
          if (rx_data[PAM_SOFT_RESET_BIT]) begin
            soft_reset_d = 1'b1;
            soft_reset_cnt_d = PAM_SOFT_RESET_CYCLES - 2'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gvc_q <= PAM_GVC_RESET;
      pll_q <= PAM_PLL_RESET;
      aid_q <= PAM_AID_RESET;
      soft_reset_q <= 1'b0;
      soft_reset_cnt_q <= 2'h0;
    end else begin
      gvc_q <= gvc_d;
      pll_q <= pll_d;
      aid_q <= aid_d;
      soft_reset_q <= soft_reset_d;
      soft_reset_cnt_q <= soft_reset_cnt_d;
    end
  end

  // pointer handling is outside the soft reset on purpose
  always_comb begin
    ptr_d = ptr_q;
    idx_d = idx_q;
    if (sel_pulse && !sel_read) begin
      idx_d = 2'h0;
    end
    if (rx_valid) begin
      case (idx_q)
        2'h0: begin
          ptr_d[15:8] = rx_data;
          idx_d = 2'h1;
        end
        2'h1: begin
          ptr_d[7:0] = rx_data;
          idx_d = 2'h2;
        end
        default: begin
          if (!aid_q) begin
            ptr_d = ptr_q + 16'h0001;
          end
        end
      endcase
    end
    if (tx_done && !aid_q) begin
      ptr_d = ptr_q + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ptr_q <= 16'h0000;
      idx_q <= 2'h0;
    end else begin
      ptr_q <= ptr_d;
      idx_q <= idx_d;
    end
  end

  // video side outputs, all registered
  always_comb begin
    tx_d = read_reg(ptr_q, gvc_q, pll_q, aid_q, soft_reset_q);
    // blank wins over everything, vertical blank only when enabled
    blank_d = gvc_q[PAM_BLANK_BIT] | (pll_q[PAM_VBE_BIT] & vblank_in);
    shut_d = gvc_q[PAM_PSAVE_BIT];
    pll_rng_d = {pll_q[PAM_PLL_HI_BIT], pll_q[PAM_PLL_LO_BIT]};
    osd_d = pll_q[PAM_OVR_BIT];
    clamp_d = clamp_in ^ pll_q[PAM_CLAMP_BIT];
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      tx_q <= 8'h00;
      sda_out_q <= 1'b0;
      blank_q <= 1'b0;
      shut_q <= 1'b0;
      pll_rng_q <= 2'h0;
      osd_q <= 1'b0;
      clamp_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      sda_out_q <= 1'b0;
      blank_q <= blank_d;
      shut_q <= shut_d;
      pll_rng_q <= pll_rng_d;
      osd_q <= osd_d;
      clamp_q <= clamp_d;
    end
  end

  assign sda_out = sda_out_q;
  assign video_blank = blank_q;
  assign analog_shutdown = shut_q;
  assign pll_range = pll_rng_q;
  assign osd_only = osd_q;
  assign clamp_active = clamp_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  AST_BLANK_FORCED: assert property (
    gvc_q[PAM_BLANK_BIT] |=> video_blank)
    else $error("blank bit set but outputs not blanked");
  AST_SHUTDOWN: assert property (
    ##1 analog_shutdown == $past(gvc_q[PAM_PSAVE_BIT]))
    else $error("shutdown does not follow power save bit");
  AST_PLL_RANGE: assert property (
    $changed(pll_q[1:0]) |=> pll_range == $past(pll_q[1:0]))
    else $error("pll range output wrong");
  AST_NO_VBLANK: assert property (
    !pll_q[PAM_VBE_BIT] && !gvc_q[PAM_BLANK_BIT] |=> !video_blank)
    else $error("blanking applied while disabled");
  AST_OVERRIDE: assert property (
    pll_q[PAM_OVR_BIT] |=> osd_only)
    else $error("override set but osd only not shown");
  AST_CLAMP: assert property (
    ##1 clamp_active == ($past(clamp_in) ^ $past(pll_q[PAM_CLAMP_BIT])))
    else $error("clamp sense wrong");
  AST_SOFT_RESET_LOADS: assert property (
    $rose(soft_reset_q) |=> gvc_q == PAM_GVC_RESET && pll_q == PAM_PLL_RESET)
    else $error("soft reset did not load defaults");
  AST_SOFT_RESET_KEEPS_BUS: assert property (
    soft_reset_q && !rx_valid && !tx_done |=> ptr_q == $past(ptr_q) && idx_q == $past(idx_q))
    else $error("soft reset disturbed bus transfer");
  AST_SOFT_RESET_SELF_CLEAR: assert property (
    $rose(soft_reset_q) |-> ##[1:4] !soft_reset_q)
    else $error("soft reset bit did not clear");
  AST_AID_HOLDS: assert property (
    tx_done && aid_q |=> ptr_q == $past(ptr_q))
    else $error("address advanced with autoinc disabled");
  AST_AUTOINC: assert property (
    tx_done && !aid_q |=> ptr_q == 16'($past(ptr_q) + 16'h0001))
    else $error("address did not advance after read byte");
  AST_SOFT_RESET_TWO_CYCLES: assert property (
    $rose(soft_reset_q) |=> soft_reset_q ##1 !soft_reset_q)
    else $error("soft reset did not last two cycles");
  AST_SOFT_RESET_HOLDS_DEFAULTS: assert property (
    soft_reset_q |=> gvc_q == PAM_GVC_RESET && pll_q == PAM_PLL_RESET)
    else $error("register left its default during soft reset");
  AST_SOFT_RESET_KEEPS_AID: assert property (
    soft_reset_q && !rx_valid |=> aid_q == $past(aid_q))
    else $error("soft reset touched its own register");
  AST_SOFT_RESET_BUS_ACK: assert property (
    $rose(soft_reset_q) |-> sda_oe ##1 sda_oe)
    else $error("soft reset cut the acknowledge");
  AST_ADDR_HI_LOAD: assert property (
    rx_valid && idx_q == 2'h0 |=> ptr_q[15:8] == $past(rx_data) && idx_q == 2'h1)
    else $error("high address byte not taken");
  AST_ADDR_LO_LOAD: assert property (
    rx_valid && idx_q == 2'h1 |=> ptr_q[7:0] == $past(rx_data) && idx_q == 2'h2)
    else $error("low address byte not taken");
  AST_AUTOINC_WRITE: assert property (
    rx_valid && idx_q == 2'h2 && !aid_q |=> ptr_q == 16'($past(ptr_q) + 16'h0001))
    else $error("address did not advance after write byte");
  AST_AID_HOLDS_WRITE: assert property (
    rx_valid && idx_q == 2'h2 && aid_q |=> ptr_q == $past(ptr_q))
    else $error("address advanced on write with autoinc disabled");
  AST_VBLANK_GATED: assert property (
    pll_q[PAM_VBE_BIT] && vblank_in |=> video_blank)
    else $error("vertical blanking not gated");
  AST_OVERRIDE_OFF: assert property (
    !pll_q[PAM_OVR_BIT] |=> !osd_only)
    else $error("osd only shown without override");
  AST_BLANK_RELEASE: assert property (
    !gvc_q[PAM_BLANK_BIT] && !(pll_q[PAM_VBE_BIT] && vblank_in) |=> !video_blank)
    else $error("outputs blanked without cause");
  AST_POWER_SAVE_ON: assert property (
    gvc_q[PAM_PSAVE_BIT] |=> analog_shutdown)
    else $error("power save set but analog still on");
  AST_READ_SRT_BITS: assert property (
    ptr_q == PAM_SRT_ADDR |=> tx_q[PAM_SOFT_RESET_BIT] == $past(soft_reset_q)
      && tx_q[PAM_AID_BIT] == $past(aid_q))
    else $error("soft reset register reads wrong");
  AST_CLAMP_POS: assert property (
    !pll_q[PAM_CLAMP_BIT] && clamp_in |=> clamp_active)
    else $error("positive clamp pulse not active");
  AST_CLAMP_NEG: assert property (
    pll_q[PAM_CLAMP_BIT] && !clamp_in |=> clamp_active)
    else $error("negative clamp pulse not active");
  AST_PLL_STEADY: assert property (
    $stable(pll_q) |=> $stable(pll_range))
    else $error("pll range moved without a write");

  COV_SOFT_RESET: cover property ($rose(soft_reset_q) ##[1:4] $fell(soft_reset_q));
  COV_DATA_WRITE: cover property (rx_valid && idx_q == 2'h2 && ptr_q == PAM_GVC_ADDR);
  COV_READ_BYTE: cover property (tx_done && !aid_q);
  COV_VBLANK: cover property (pll_q[PAM_VBE_BIT] && vblank_in ##1 video_blank);
  COV_FROZEN_READ: cover property (tx_done && aid_q);
endmodule : pam_global_ctrl

// *** logic/pam_pkg.sv ***
package pam_pkg;
  // register addresses on the serial control bus
  localparam logic [15:0] PAM_GVC_ADDR = 16'h8439;
  localparam logic [15:0] PAM_PLL_ADDR = 16'h843E;
  localparam logic [15:0] PAM_SRT_ADDR = 16'h843F;
  // global_video_control fields
  localparam int PAM_BLANK_BIT = 0;
  localparam int PAM_PSAVE_BIT = 1;
  // pll_range_and_video_options fields
  localparam int PAM_PLL_LO_BIT = 0;
  localparam int PAM_PLL_HI_BIT = 1;
  localparam int PAM_VBE_BIT = 2;
  localparam int PAM_OVR_BIT = 3;
  localparam int PAM_CLAMP_BIT = 5;
  // soft_reset_and_test_control fields
  localparam int PAM_SOFT_RESET_BIT = 0;
  localparam int PAM_AID_BIT = 6;
  // writable bits; reserved bits store nothing and read zero
  localparam logic [7:0] PAM_GVC_MASK = 8'h03;
  localparam logic [7:0] PAM_PLL_MASK = 8'h2F;
  // reset values
  localparam logic [7:0] PAM_GVC_RESET = 8'h00;
  localparam logic [7:0] PAM_PLL_RESET = 8'h00;
  localparam logic PAM_AID_RESET = 1'b0;
  localparam logic [7:0] PAM_UNMAPPED_READ = 8'h00;
  // soft reset length in clock cycles
  localparam logic [1:0] PAM_SOFT_RESET_CYCLES = 2'h2;
  // serial bus device address, arbitrary value
  localparam logic [6:0] PAM_DEV_ADDR = 7'h2C;
  // bits per byte on the serial bus
  localparam logic [3:0] PAM_BYTE_BITS = 4'h8;
endpackage : pam_pkg

// *** logic/pam_i2c_slave.sv ***
`timescale 1ns/100ps
module pam_i2c_slave
  import pam_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = PAM_DEV_ADDR
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic select_pulse,
  output logic select_read,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic [7:0] tx_data,
  output logic tx_done
);
  typedef enum logic [2:0] {
    PAM_IDLE, PAM_ADDR, PAM_ACK, PAM_WRITE, PAM_READ, PAM_MACK
  } pam_i2c_state_t;

  pam_i2c_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic oe_q, oe_d;
  logic scl_q, sda_q;
  logic sel_q, sel_d;
  logic rxv_q, rxv_d;
  logic txd_q, txd_d;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_d = oe_q;
    sel_d = 1'b0;
    rxv_d = 1'b0;
    txd_d = 1'b0;
    if (start_cond) begin
      state_d = PAM_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_cond) begin
      state_d = PAM_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        PAM_ADDR, PAM_WRITE: begin
          if (cnt_q < PAM_BYTE_BITS) begin
            shift_d = {shift_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
          end
        end
        PAM_MACK: begin
          nack_d = sda_in;
          txd_d = 1'b1;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        PAM_ADDR: begin
          if (cnt_q == PAM_BYTE_BITS) begin
            if (shift_q[7:1] == DEV_ADDR) begin
              state_d = PAM_ACK;
              oe_d = 1'b1;
              rw_d = shift_q[0];
              sel_d = 1'b1;
            end else begin
              state_d = PAM_IDLE;
            end
          end
        end
        PAM_WRITE: begin
          if (cnt_q == PAM_BYTE_BITS) begin
            state_d = PAM_ACK;
            oe_d = 1'b1;
            rxv_d = 1'b1;
          end
        end
        PAM_ACK: begin
          if (rw_q) begin
            state_d = PAM_READ;
            shift_d = tx_data;
            oe_d = ~tx_data[7];
            cnt_d = 4'h1;
          end else begin
            state_d = PAM_WRITE;
            oe_d = 1'b0;
            cnt_d = 4'h0;
          end
        end
        PAM_READ: begin
          if (cnt_q == PAM_BYTE_BITS) begin
            state_d = PAM_MACK;
            oe_d = 1'b0;
          end else begin
            shift_d = {shift_q[6:0], 1'b0};
            oe_d = ~shift_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
        PAM_MACK: begin
          // a nack ends the read; the master then sends stop
          if (nack_q) begin
            state_d = PAM_IDLE;
          end else begin
            state_d = PAM_READ;
            shift_d = tx_data;
            oe_d = ~tx_data[7];
            cnt_d = 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_q <= PAM_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sel_q <= 1'b0;
      rxv_q <= 1'b0;
      txd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      scl_q <= scl_in;
      sda_q <= sda_in;
      sel_q <= sel_d;
      rxv_q <= rxv_d;
      txd_q <= txd_d;
    end
  end

  assign sda_oe = oe_q;
  assign select_pulse = sel_q;
  assign select_read = rw_q;
  assign rx_valid = rxv_q;
  assign rx_data = shift_q;
  assign tx_done = txd_q;
endmodule : pam_i2c_slave

// *** dv/pam_bus_master.sv ***
`timescale 1ns/100ps
module pam_bus_master (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  // 4 clocks per step, above the 3 clock minimum phase
  task automatic step(input logic c, input logic d);
    @(negedge clock);
    scl <= c;
    sda_drv <= d;
    repeat (3) @(negedge clock);
  endtask : step

  // data moves only while scl is low, never beside a scl edge
  task automatic bit_io(input logic d, output logic q);
    step(1'h0, sda_drv);
    step(1'h0, d);
    step(1'h1, d);
    q = sda_line;
  endtask : bit_io

  task automatic start();
    step(1'h0, sda_drv);
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
  endtask : start

  task automatic stop();
    step(1'h0, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
  endtask : stop

  // reads send all ones so the wire is left to the device
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                         output logic ack_seen);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], b);
      rx[i] = b;
    end
    bit_io(ack_in, ack_seen);
  endtask : byte_io
endmodule : pam_bus_master

// *** dv/tb_preamp_global_control_regs.sv ***
`timescale 1ns/100ps
module tb_preamp_global_control_regs;
  import pam_pkg::*;
  logic clock;
  logic reset_n;
  logic vblank_in;
  logic clamp_in;
  logic scl;
  logic sda_drv;
  logic sda_line;
  logic sda_out;
  logic sda_oe;
  logic video_blank;
  logic analog_shutdown;
  logic [1:0] pll_range;
  logic osd_only;
  logic clamp_active;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] tbl[4];

  // pull-up on the shared data line
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'h1);

  pam_global_ctrl uut (.clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .vblank_in(vblank_in), .clamp_in(clamp_in),
    .video_blank(video_blank), .analog_shutdown(analog_shutdown), .pll_range(pll_range),
    .osd_only(osd_only), .clamp_active(clamp_active));
  pam_bus_master mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // whole run needs roughly 16k clocks
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic put(input logic [7:0] b);
    logic [7:0] rx;
    logic ak;
    mst.byte_io(b, 1'h1, rx, ak);
    check("ack", {7'h00, ak}, 8'h00);
  endtask : put

  // write nw bytes from wd, point back at addr, then read nr bytes against rd
  task automatic xact(input logic [15:0] addr, input int nw, input logic [15:0] wd,
                      input int nr, input logic [15:0] rd);
    logic [7:0] rx;
    logic ak;
    mst.start();
    put({PAM_DEV_ADDR, 1'h0});
    put(addr[15:8]);
    put(addr[7:0]);
    for (int i = 0; i < nw; i++) begin
      put(wd[15 - 8 * i -: 8]);
    end
    if (nr > 0) begin
      // unless autoinc is disabled the written bytes moved the pointer on, so set it again
      if (nw > 0) begin
        mst.start();
        put({PAM_DEV_ADDR, 1'h0});
        put(addr[15:8]);
        put(addr[7:0]);
      end
      mst.start();
      put({PAM_DEV_ADDR, 1'h1});
      for (int i = 0; i < nr; i++) begin
        mst.byte_io(8'hFF, (i == nr - 1), rx, ak);
        check("read data", rx, rd[15 - 8 * i -: 8]);
      end
    end
    mst.stop();
    repeat (4) @(negedge clock);
  endtask : xact

  task automatic t_reset();
    check("blank", {7'h00, video_blank}, 8'h00);
    check("pll", {6'h00, pll_range}, 8'h00);
    xact(PAM_PLL_ADDR, 0, 16'h0000, 2, 16'h0000);
    xact(16'h8440, 0, 16'h0000, 1, 16'h0000);
  endtask : t_reset

  task automatic t_global();
    tbl = '{8'h01, 8'h02, 8'h03, 8'h00};
    foreach (tbl[i]) begin
      xact(PAM_GVC_ADDR, 1, {tbl[i], 8'h00}, 1, {tbl[i], 8'h00});
      check("blank", {7'h00, video_blank}, {7'h00, tbl[i][0]});
      check("shutdown", {7'h00, analog_shutdown}, {7'h00, tbl[i][1]});
    end
  endtask : t_global

  task automatic t_pll();
    vblank_in = 1'h1;
    clamp_in = 1'h1;
    tbl = '{8'h01, 8'h06, 8'h0B, 8'h20};
    foreach (tbl[i]) begin
      xact(PAM_PLL_ADDR, 1, {tbl[i], 8'h00}, 0, 16'h0000);
      check("pll", {6'h00, pll_range}, {6'h00, tbl[i][1:0]});
      check("vblank", {7'h00, video_blank}, {7'h00, tbl[i][2]});
      check("osd", {7'h00, osd_only}, {7'h00, tbl[i][3]});
      check("clamp hi", {7'h00, clamp_active}, {7'h00, ~tbl[i][5]});
      clamp_in = 1'h0;
      repeat (3) @(negedge clock);
      check("clamp lo", {7'h00, clamp_active}, {7'h00, tbl[i][5]});
      clamp_in = 1'h1;
    end
    vblank_in = 1'h0;
  endtask : t_pll

  task automatic t_autoinc();
    xact(PAM_PLL_ADDR, 0, 16'h0000, 2, 16'h2000);
    xact(PAM_GVC_ADDR, 2, 16'h0201, 0, 16'h0000);
    xact(PAM_GVC_ADDR, 0, 16'h0000, 1, 16'h0200);
    xact(PAM_SRT_ADDR, 1, 16'h4000, 1, 16'h4000);
    xact(PAM_PLL_ADDR, 0, 16'h0000, 2, 16'h2020);
    xact(PAM_GVC_ADDR, 2, 16'h0301, 1, 16'h0100);
    check("blank", {7'h00, video_blank}, 8'h01);
    check("shutdown", {7'h00, analog_shutdown}, 8'h00);
  endtask : t_autoinc

  // reset byte and read-back share one transfer, which must survive the reset
  task automatic t_soft_reset();
    xact(PAM_PLL_ADDR, 1, 16'h2F00, 0, 16'h0000);
    check("pll", {6'h00, pll_range}, 8'h03);
    xact(PAM_SRT_ADDR, 1, 16'h4100, 1, 16'h4000);
    check("blank", {7'h00, video_blank}, 8'h00);
    check("pll", {6'h00, pll_range}, 8'h00);
    check("osd", {7'h00, osd_only}, 8'h00);
    xact(PAM_GVC_ADDR, 0, 16'h0000, 1, 16'h0000);
    xact(PAM_PLL_ADDR, 0, 16'h0000, 1, 16'h0000);
    xact(PAM_SRT_ADDR, 0, 16'h0000, 1, 16'h4000);
  endtask : t_soft_reset

  initial begin
    reset_n = 1'h0;
    vblank_in = 1'h0;
    clamp_in = 1'h0;
    repeat (8) @(negedge clock);
    reset_n = 1'h1;
    repeat (4) @(negedge clock);
    t_reset();
    t_global();
    t_pll();
    t_autoinc();
    t_soft_reset();
    give_verdict();
  end
endmodule : tb_preamp_global_control_regs
